/* File: hw/msd_pkg.sv */
/*
 Package for the muting state and diagnostics block: state codes,
 diagnostic bit positions, timing constants and carrier structs.
 Assumes nothing of its surroundings.
*/
package msd_pkg;

   // State codes, 8-bit
   typedef enum logic [7:0] {
      MSD_ST_UNDEF  = 8'h00,
      MSD_ST_RUN    = 8'h01,
      MSD_ST_STOP   = 8'h02,
      MSD_ST_SAFE   = 8'h03,
      MSD_ST_ERROR  = 8'h04,
      MSD_ST_RESET  = 8'h05,
      MSD_ST_DELAY  = 8'h08,
      MSD_ST_PH1    = 8'h09,
      MSD_ST_PH2    = 8'h0a,
      MSD_ST_PH3    = 8'h0b,
      MSD_ST_PH4    = 8'h0c,
      MSD_ST_PH5    = 8'h0d,
      MSD_ST_PH6    = 8'h0e,
      MSD_ST_PH7    = 8'h0f,
      MSD_ST_PH8    = 8'h10,
      MSD_ST_PH9    = 8'h11
   } msd_state_t;

   localparam logic [7:0] MSD_PHASE_FIRST = 8'h09;
   localparam logic [7:0] MSD_PHASE_LAST  = 8'h11;

   // Diagnostic word bit positions
   localparam int MSD_DG_DISC_M1   = 0;
   localparam int MSD_DG_DISC_OSSD = 1;
   localparam int MSD_DG_DISC_M2   = 2;
   localparam int MSD_DG_FB_DIRECT = 4;
   localparam int MSD_DG_FB_DELAY  = 5;
   localparam int MSD_DG_SEQ       = 6;
   localparam int MSD_DG_MAXTIME   = 7;
   localparam int MSD_DG_PEND_M1   = 8;
   localparam int MSD_DG_PEND_OSSD = 9;
   localparam int MSD_DG_PEND_M2   = 10;
   localparam logic [15:0] MSD_DIAG_RESET = 16'h0000;

   // Timing, 100 MHz clock
   localparam int MSD_CLK_MHZ       = 100;
   localparam int MSD_DELAY_MS      = 500;
   localparam int MSD_DELAY_CYC     = MSD_DELAY_MS * 1000 * MSD_CLK_MHZ;
   localparam int MSD_DISC_MS       = 250;
   localparam int MSD_DISC_CYC      = MSD_DISC_MS * 1000 * MSD_CLK_MHZ;
   localparam int MSD_FB_MS         = 200;
   localparam int MSD_FB_CYC        = MSD_FB_MS * 1000 * MSD_CLK_MHZ;
   localparam int MSD_MAXMUTE_MIN   = 10;
   localparam longint MSD_MAXMUTE_CYC = longint'(MSD_MAXMUTE_MIN) * 60 * 1000000 * MSD_CLK_MHZ;

   // Raw pin inputs
   typedef struct packed {
      logic curtain_channel_one;
      logic curtain_channel_two;
      logic bypass_sensor_one;
      logic bypass_sensor_two;
      logic bypass_sensor_three;
      logic bypass_sensor_four;
      logic feedback_loop_direct;
      logic feedback_loop_delayed;
   } msd_pins_t;

   // Outputs to the owning group
   typedef struct packed {
      logic direct_safe_output;
      logic delayed_safe_output;
      logic bypass_indicator;
      logic error_flag;
   } msd_outs_t;

endpackage

/* File: hw/msd_muting_state_diag.sv */
/*
 Muting state machine with diagnostic word and state code.
 Assumes pin inputs are asynchronous (synchronised here), and that the
 run permit, enables and acknowledge come from logic on the same clock.
*/
// Summary of operation
// RL1 - Bits 0..2 flag discrepancy in mute group one, curtain pair, mute group two
// RL2 - Bits 4 and 5 flag feedback check failure of direct and delayed outputs
// RL3 - Bit 6 flags muting sensors operated out of order
// RL4 - Bit 7 flags muting lasting longer than the maximum time
// RL5 - Bits 8..10 show discrepancy conditions not yet cleared
// RL6 - State code is 8 bits; 0 undefined, 6 and 7 never reported
// RL7 - Run state 1: field clear, no muting; both outputs on
// RL8 - Stop state 2 whenever run permit is low; all outputs off
// RL9 - Safe state 3 after delay expires with field broken, no muting
// RL10 - Any error enters state 4 with error flag set, outputs off
// RL11 - Reset state 5 only when no error pending and acknowledge true
// RL12 - Delay state 8: direct output off, delayed output still on
// RL13 - Discrepancy in state 8 waits for delay end before error
// RL14 - Nine muting phases 9..17 with indicator and both outputs on
// RL15 - Without muting, broken field switches direct output off immediately
// RL16 - Discrepancy monitoring only with non-zero time, starts on safe request
// RL17 - With feedback active, output leaves safe state only if feedback is one; here it switches on regardless, and a mismatch lasting FB_CYC is an error
// RL18 - Error flag holds until group acknowledge resets it; run permit low also clears it through stop state 2
// RL19 - Only the expected sensor transition advances a phase; others are errors
`timescale 1ns/1ps
module msd_muting_state_diag
   import msd_pkg::*;
#(
   parameter int     DELAY_CYC   = MSD_DELAY_CYC,
   parameter int     DISC_CYC    = MSD_DISC_CYC,
   parameter int     FB_CYC      = MSD_FB_CYC,
   parameter longint MAXMUTE_CYC = MSD_MAXMUTE_CYC
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   // Configuration
   input  wire logic        disc_check_enable,
   input  wire logic        feedback_direct_enable,
   input  wire logic        feedback_delayed_enable,
   input  wire logic        max_time_enable,
   // Group control
   input  wire logic        block_run_permit,
   input  wire logic        group_error_acknowledge,
   input  wire logic        bypass_enable_request,
   // Field pins
   input  wire msd_pins_t   pins,
   // Outputs
   output msd_outs_t        outs,
   output logic [15:0]      fault_diagnostic_word,
   output logic [7:0]       machine_state_code
);

   localparam int PINW = $bits(msd_pins_t);

   logic [PINW-1:0] s1_r, s2_r, s3_r, clean_r;
   msd_pins_t       in_c;
   msd_state_t      st_r, st_nxt;
   logic [31:0]     delay_cnt_r;
   logic [63:0]     mute_cnt_r;
   logic [31:0]     disc_cnt_r [3];
   logic [31:0]     fb_cnt_r [2];
   logic [2:0]      disc_err, disc_pend;
   logic [1:0]      fb_err;
   logic [3:0]      mute_prev_r;
   logic [3:0]      mute_now;
   logic            seq_err, max_err, any_err;
   logic [15:0]     diag_r;
   logic            protective_field_clear;
   logic            delay_done;

   // Three-stage sync; change counts when stages two and three agree
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_r    <= '0;
         s2_r    <= '0;
         s3_r    <= '0;
         clean_r <= '0;
      end else if (clk_en) begin
         s1_r <= pins;
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (int i = 0; i < PINW; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               clean_r[i] <= s3_r[i];
            end
         end
      end
   end
   assign in_c = msd_pins_t'(clean_r);

   assign protective_field_clear = in_c.curtain_channel_one & in_c.curtain_channel_two;
   assign mute_now = {in_c.bypass_sensor_four, in_c.bypass_sensor_three,
                      in_c.bypass_sensor_two, in_c.bypass_sensor_one};

   // Discrepancy timers for the three channel pairs
   logic [1:0] pair_in [3];
   assign pair_in[0] = {in_c.bypass_sensor_one, in_c.bypass_sensor_two};
   assign pair_in[1] = {in_c.curtain_channel_one, in_c.curtain_channel_two};
   assign pair_in[2] = {in_c.bypass_sensor_three, in_c.bypass_sensor_four};

   // RL16 gated discrepancy monitor
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < 3; i++) begin
            disc_cnt_r[i] <= 32'h0;
         end
      end else if (clk_en) begin
         for (int i = 0; i < 3; i++) begin
            if (!disc_check_enable || DISC_CYC == 0 || (pair_in[i][0] == pair_in[i][1])) begin
               disc_cnt_r[i] <= 32'h0;
            end else if (disc_cnt_r[i] < 32'(DISC_CYC)) begin
               disc_cnt_r[i] <= disc_cnt_r[i] + 32'h1;
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         disc_err[i]  = (disc_cnt_r[i] >= 32'(DISC_CYC)) && disc_check_enable && (DISC_CYC != 0);
         disc_pend[i] = disc_err[i];
      end
   end

   // RL17 feedback must follow output to leave safe state; here a mismatch lasting FB_CYC is an error
   always_ff @(posedge clk) begin
      if (rst) begin
         fb_cnt_r[0] <= 32'h0;
         fb_cnt_r[1] <= 32'h0;
      end else if (clk_en) begin
         if (!feedback_direct_enable || (outs.direct_safe_output == in_c.feedback_loop_direct)) begin
            fb_cnt_r[0] <= 32'h0;
         end else if (fb_cnt_r[0] < 32'(FB_CYC)) begin
            fb_cnt_r[0] <= fb_cnt_r[0] + 32'h1;
         end
         if (!feedback_delayed_enable || (outs.delayed_safe_output == in_c.feedback_loop_delayed)) begin
            fb_cnt_r[1] <= 32'h0;
         end else if (fb_cnt_r[1] < 32'(FB_CYC)) begin
            fb_cnt_r[1] <= fb_cnt_r[1] + 32'h1;
         end
      end
   end
   assign fb_err[0] = fb_cnt_r[0] >= 32'(FB_CYC);
   assign fb_err[1] = fb_cnt_r[1] >= 32'(FB_CYC);

   // Muting sequence: phase n expects sensor (n-1) mod 4 to toggle
   logic       in_phase;
   logic [7:0] ph_idx;
   logic [1:0] exp_sensor;
   logic       sensor_moved, exp_moved, mute_end;
   assign in_phase     = (st_r >= MSD_PHASE_FIRST) && (st_r <= MSD_PHASE_LAST);
   assign ph_idx       = 8'(st_r - MSD_PHASE_FIRST);
   assign exp_sensor   = 2'(ph_idx % 8'h04);
   assign sensor_moved = (mute_now != mute_prev_r);
   assign exp_moved    = ((mute_now ^ mute_prev_r) == (4'h1 << exp_sensor));
   assign mute_end     = (st_r == MSD_PHASE_LAST) && exp_moved;
   // RL19 unexpected transition is a violation
   assign seq_err      = in_phase && sensor_moved && !exp_moved;

   always_ff @(posedge clk) begin
      if (rst) begin
         mute_prev_r <= 4'h0;
      end else if (clk_en) begin
         mute_prev_r <= mute_now;
      end
   end

   // Maximum muting time, limited by the long count parameter
   always_ff @(posedge clk) begin
      if (rst) begin
         mute_cnt_r <= 64'h0;
      end else if (clk_en) begin
         if (!in_phase) begin
            mute_cnt_r <= 64'h0;
         end else if (mute_cnt_r < 64'(MAXMUTE_CYC)) begin
            mute_cnt_r <= mute_cnt_r + 64'h1;
         end
      end
   end
   // RL4 overtime flag
   assign max_err = max_time_enable && in_phase && (mute_cnt_r >= 64'(MAXMUTE_CYC));

   // Output delay timer runs while in delay state
   always_ff @(posedge clk) begin
      if (rst) begin
         delay_cnt_r <= 32'h0;
      end else if (clk_en) begin
         if (st_r != MSD_ST_DELAY) begin
            delay_cnt_r <= 32'h0;
         end else if (delay_cnt_r < 32'(DELAY_CYC)) begin
            delay_cnt_r <= delay_cnt_r + 32'h1;
         end
      end
   end
   assign delay_done = (delay_cnt_r + 32'h1) >= 32'(DELAY_CYC);

   assign any_err = (|disc_err) || (|fb_err) || seq_err || max_err;

   // Next state
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         MSD_ST_ERROR: begin
            // RL11 acknowledge only without pending error
            if (!any_err && group_error_acknowledge) begin
               st_nxt = MSD_ST_RESET;
            end
         end
         MSD_ST_DELAY: begin
            // RL13 error waits for delay end
            // RL9 delay expiry to safe
            if (delay_done) begin
               st_nxt = any_err ? MSD_ST_ERROR : MSD_ST_SAFE;
            end else if (protective_field_clear && !any_err) begin
               st_nxt = MSD_ST_RUN;
            end
         end
         MSD_ST_UNDEF, MSD_ST_STOP, MSD_ST_RESET, MSD_ST_SAFE, MSD_ST_RUN: begin
            if (any_err) begin
               st_nxt = MSD_ST_ERROR;
            end else if (bypass_enable_request && protective_field_clear && mute_now == 4'h1
                         && mute_prev_r == 4'h0) begin
               // RL14 first sensor starts the phases
               st_nxt = MSD_ST_PH1;
            end else if (protective_field_clear) begin
               // RL7 clear field runs
               st_nxt = MSD_ST_RUN;
            end else if (st_r == MSD_ST_RUN) begin
               // RL12 broken field starts delay
               st_nxt = MSD_ST_DELAY;
            end else begin
               st_nxt = MSD_ST_SAFE;
            end
         end
         default: begin
            // RL10 any error from a phase
            if (any_err) begin
               st_nxt = MSD_ST_ERROR;
            end else if (!bypass_enable_request) begin
               // RL15 muting withdrawn acts as no muting
               st_nxt = protective_field_clear ? MSD_ST_RUN : MSD_ST_DELAY;
            end else if (mute_end) begin
               st_nxt = MSD_ST_RUN;
            end else if (exp_moved) begin
               st_nxt = msd_state_t'(8'(st_r + 8'h01));
            end
         end
      endcase
      // RL8 run permit overrides all
      if (!block_run_permit) begin
         st_nxt = MSD_ST_STOP;
      end
   end

   // RL6 only legal codes are held
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= MSD_ST_STOP;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   // Diagnostic bits stick until an acknowledged reset; set wins over clear
   logic [15:0] diag_set;
   always_comb begin
      diag_set = 16'h0000;
      // RL1 discrepancy bits
      diag_set[MSD_DG_DISC_M1]   = disc_err[0];
      diag_set[MSD_DG_DISC_OSSD] = disc_err[1];
      diag_set[MSD_DG_DISC_M2]   = disc_err[2];
      // RL2 feedback bits
      diag_set[MSD_DG_FB_DIRECT] = fb_err[0];
      diag_set[MSD_DG_FB_DELAY]  = fb_err[1];
      // RL3 sequence bit
      diag_set[MSD_DG_SEQ]       = seq_err;
      diag_set[MSD_DG_MAXTIME]   = max_err;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         diag_r <= MSD_DIAG_RESET;
      end else if (clk_en) begin
         if (st_nxt == MSD_ST_RESET) begin
            diag_r <= diag_set;
         end else begin
            diag_r <= diag_r | diag_set;
         end
      end
   end

   // Registered outputs from the next state
   always_ff @(posedge clk) begin
      if (rst) begin
         outs                  <= '0;
         fault_diagnostic_word <= MSD_DIAG_RESET;
         machine_state_code    <= MSD_ST_STOP;
      end else if (clk_en) begin
         machine_state_code <= st_nxt;
         fault_diagnostic_word <= (st_nxt == MSD_ST_RESET ? diag_set : (diag_r | diag_set));
         // RL5 pending bits live
         fault_diagnostic_word[MSD_DG_PEND_M1]   <= disc_pend[0];
         fault_diagnostic_word[MSD_DG_PEND_OSSD] <= disc_pend[1];
         fault_diagnostic_word[MSD_DG_PEND_M2]   <= disc_pend[2];
         // RL18 error flag only in error state
         outs.error_flag <= (st_nxt == MSD_ST_ERROR);
         outs.bypass_indicator <= (st_nxt >= MSD_PHASE_FIRST) && (st_nxt <= MSD_PHASE_LAST);
         outs.direct_safe_output <= (st_nxt == MSD_ST_RUN) ||
                                    ((st_nxt >= MSD_PHASE_FIRST) && (st_nxt <= MSD_PHASE_LAST));
         outs.delayed_safe_output <= (st_nxt == MSD_ST_RUN) || (st_nxt == MSD_ST_DELAY) ||
                                     ((st_nxt >= MSD_PHASE_FIRST) && (st_nxt <= MSD_PHASE_LAST));
      end
   end

endmodule

/* File: test/msd_state_checker.sv */
/*
 Assertions for the muting state block.
 Bound to the block top; sees its ports only.
*/
`timescale 1ns/1ps
module msd_state_checker
   import msd_pkg::*;
#(
   parameter int DELAY_CYC = 20
) (
   // Clock, reset and controls
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        clk_en,
   input wire logic        block_run_permit,
   input wire logic        group_error_acknowledge,
   // Block outputs
   input wire msd_outs_t   outs,
   input wire logic [15:0] fault_diagnostic_word,
   input wire logic [7:0]  machine_state_code
);
   logic [31:0] dcnt_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Cycles spent in the delay state; clk_en low freezes it too
   always_ff @(posedge clk) begin
      if (rst) begin
         dcnt_r <= 32'h0;
      end else if (clk_en) begin
         dcnt_r <= (machine_state_code == 8'h08) ? dcnt_r + 32'h1 : 32'h0;
      end
   end

   // Leaving the delay state, to safe or to error
   sequence delay_to_safe;
      machine_state_code == 8'h08 ##1 machine_state_code == 8'h03;
   endsequence
   sequence delay_to_error;
      machine_state_code == 8'h08 ##1 machine_state_code == 8'h04;
   endsequence

   state_code_legal_a: assert property (
      !(machine_state_code inside {8'h00, 8'h06, 8'h07}) && machine_state_code <= 8'h11)
      else $error("illegal state code");
   run_outs_a: assert property (machine_state_code == 8'h01 |-> outs == 4'hc)
      else $error("run outputs wrong");
   stop_entry_a: assert property (!block_run_permit && clk_en |=>
      machine_state_code == 8'h02 && outs == 4'h0) else $error("stop not entered");
   safe_outs_a: assert property (machine_state_code == 8'h03 |-> outs == 4'h0)
      else $error("safe outputs wrong");
   error_outs_a: assert property (machine_state_code == 8'h04 ##1 machine_state_code == 8'h04
      |-> outs == 4'h1 && fault_diagnostic_word[7:0] != 8'h00) else $error("error outputs wrong");
   reset_entry_a: assert property (
      machine_state_code == 8'h05 && $past(machine_state_code) == 8'h04
      |-> $past(group_error_acknowledge) && outs == 4'h0) else $error("reset without ack");
   delay_outs_a: assert property (machine_state_code == 8'h08 |-> outs == 4'h4)
      else $error("delay outputs wrong");
   phase_outs_a: assert property (
      machine_state_code inside {[8'h09:8'h11]} |-> outs == 4'he) else $error("phase outputs wrong");
   error_hold_a: assert property (
      machine_state_code == 8'h04 && !group_error_acknowledge && block_run_permit
      |=> machine_state_code == 8'h04) else $error("error left without ack");
   delay_time_a: assert property (delay_to_safe |->
      dcnt_r inside {[DELAY_CYC - 1:DELAY_CYC + 1]}) else $error("delay length wrong");
   disc_wait_a: assert property (delay_to_error |-> dcnt_r >= DELAY_CYC - 1)
      else $error("error before delay end");
endmodule

/* File: test/msd_field_model.sv */
/*
 Field side model: curtain, muting sensors, feedback contacts.
 Levels come from the bench; contacts follow the block outputs.
*/
`timescale 1ns/1ps
module msd_field_model
   import msd_pkg::*;
(
   // Clock
   input  wire logic       clk,
   // Levels from the bench
   input  wire logic [1:0] curtain,
   input  wire logic [3:0] sensors,
   input  wire logic [1:0] fb_fault,
   // Block side
   input  wire msd_outs_t  outs,
   output msd_pins_t       pins
);
   logic [1:0] fb_r;

   // contacts follow outputs
   // One cycle relay lag; a fault inverts the contact
   always_ff @(posedge clk) begin
      fb_r <= {outs.delayed_safe_output, outs.direct_safe_output} ^ fb_fault;
   end

   // Pin order as the block's struct expects
   assign pins = {curtain[0], curtain[1], sensors[0], sensors[1], sensors[2], sensors[3], fb_r[0], fb_r[1]};
endmodule

/* File: test/msd_muting_state_diag_test.sv */
/*
 Self-checking bench for the muting state block.
 Uses the field model and the bound checker; short delay counts.
*/
`timescale 1ns/1ps
module msd_muting_state_diag_test
   import msd_pkg::*;
;
   localparam int DLY = 20;
   logic        clk, rst, clk_en, disc, fbd, fbl, mxt, permit, ack, en;
   logic [1:0]  curtain, fb_fault;
   logic [3:0]  sensors;
   msd_pins_t   pins;
   msd_outs_t   outs;
   logic [15:0] diag;
   logic [7:0]  st;
   int          failures, total_checks, cycles, k, n, w;

   msd_field_model fm_u (.clk(clk), .curtain(curtain), .sensors(sensors), .fb_fault(fb_fault),
      .outs(outs), .pins(pins));
   msd_muting_state_diag #(.DELAY_CYC(DLY), .DISC_CYC(10), .FB_CYC(10), .MAXMUTE_CYC(100)) dut_u (
      .clk(clk), .rst(rst), .clk_en(clk_en), .disc_check_enable(disc), .feedback_direct_enable(fbd),
      .feedback_delayed_enable(fbl), .max_time_enable(mxt), .block_run_permit(permit),
      .group_error_acknowledge(ack), .bypass_enable_request(en), .pins(pins), .outs(outs),
      .fault_diagnostic_word(diag), .machine_state_code(st));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard, well above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         complete_run();
      end
   end

   task automatic complete_run();
      if (failures == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Output pattern each state should show
   function automatic logic [3:0] exp_outs(input logic [7:0] s);
      if (s == 8'h01) return 4'hc;
      if (s == 8'h04) return 4'h1;
      if (s == 8'h08) return 4'h4;
      if (s >= 8'h09 && s <= 8'h11) return 4'he;
      return 4'h0;
   endfunction

   // Bounded wait for a state, then check code and outputs
   task automatic wait_for(input logic [7:0] s, input int lim);
      int i;
      i = 0;
      while (st !== s && i < lim) begin
         @(negedge clk);
         i++;
      end
      chk({8'h00, st}, {8'h00, s});
      chk({12'h000, outs}, {12'h000, exp_outs(s)});
   endtask

   // Clear every cause, acknowledge, back to run
   task automatic recover();
      sensors = 4'h0;
      curtain = 2'b11;
      fb_fault = 2'b00;
      ack = 1'b1;
      wait_for(8'h05, 20);
      ack = 1'b0;
      wait_for(8'h01, 10);
      chk(diag, 16'h0000);
   endtask

   initial begin
      {clk_en, rst, curtain} = 4'hf;
      {disc, fbd, fbl, mxt, permit, ack, en, fb_fault, sensors} = 13'h0;
      {failures, total_checks, cycles} = 0;
      void'($urandom(32'hdc76afa5));
      repeat (4) @(negedge clk);
      rst = 1'b0;
      chk({8'h00, st}, 16'h0002);
      chk(diag, 16'h0000);
      permit = 1'b1;
      wait_for(8'h01, 20);
      curtain = 2'b00;
      wait_for(8'h08, 10);
      wait_for(8'h03, DLY + 5);
      curtain = 2'b11;
      wait_for(8'h01, 10);
      for (k = 0; k < 4; k++) begin
         permit = 1'b0;
         repeat ($urandom_range(1, 8)) @(negedge clk);
         chk({8'h00, st}, 16'h0002);
         permit = 1'b1;
         wait_for(8'h01, 5);
      end
      // Full muting run: each phase wants one sensor toggle
      en = 1'b1;
      sensors = 4'h1;
      wait_for(8'h09, 10);
      for (n = 9; n <= 17; n++) begin
         sensors[(n - 9) % 4] = ~sensors[(n - 9) % 4];
         wait_for((n == 17) ? 8'h01 : 8'(n + 1), 10);
      end
      // Muting bridges a broken field; withdrawing it cuts the direct output at once
      sensors = 4'h1;
      wait_for(8'h09, 10);
      curtain = 2'b00;
      repeat (8) @(negedge clk);
      chk({8'h00, st}, 16'h0009);
      chk({12'h000, outs}, 16'h000e);
      en = 1'b0;
      wait_for(8'h08, 5);
      curtain = 2'b11;
      sensors = 4'h0;
      wait_for(8'h01, 10);
      en = 1'b1;
      // Wrong sensor, picked at random
      sensors = 4'h1;
      wait_for(8'h09, 10);
      w = $urandom_range(1, 3);
      sensors[w] = ~sensors[w];
      wait_for(8'h04, 10);
      chk(diag, 16'h0040);
      repeat (30) @(negedge clk);
      chk({8'h00, st}, 16'h0004);
      recover();
      mxt = 1'b1;
      sensors = 4'h1;
      wait_for(8'h09, 10);
      wait_for(8'h04, 130);
      chk(diag, 16'h0080);
      {mxt, en} = 2'b00;
      recover();
      // Curtain channels disagree inside the delay
      disc = 1'b1;
      curtain = 2'b01;
      wait_for(8'h08, 10);
      repeat (15) @(negedge clk);
      chk({8'h00, st}, 16'h0008);
      wait_for(8'h04, 20);
      chk(diag, 16'h0202);
      curtain = 2'b11;
      repeat (8) @(negedge clk);
      chk(diag, 16'h0002);
      recover();
      // Muting pair discrepancy, group picked at random, muting off
      w = $urandom_range(0, 1);
      sensors = (w == 1) ? 4'h4 : 4'h1;
      wait_for(8'h04, 20);
      chk(diag, (w == 1) ? 16'h0404 : 16'h0101);
      recover();
      disc = 1'b0;
      for (k = 0; k < 2; k++) begin
         {fbl, fbd} = (k == 0) ? 2'b01 : 2'b10;
         fb_fault[k] = 1'b1;
         wait_for(8'h04, 40);
         chk(diag, (k == 0) ? 16'h0010 : 16'h0020);
         recover();
      end
      // Enable low freezes all state; the broken field counts once it returns
      clk_en = 1'b0;
      curtain = 2'b00;
      repeat (10) @(negedge clk);
      chk({8'h00, st}, 16'h0001);
      chk({12'h000, outs}, 16'h000c);
      clk_en = 1'b1;
      wait_for(8'h08, 10);
      // Reset in mid-run, out of the delay state
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      chk({8'h00, st}, 16'h0002);
      chk(diag, 16'h0000);
      wait_for(8'h03, 10);
      complete_run();
   end
endmodule

bind msd_muting_state_diag msd_state_checker #(.DELAY_CYC(DELAY_CYC)) chk_u (
   .clk(clk), .rst(rst), .clk_en(clk_en), .block_run_permit(block_run_permit),
   .group_error_acknowledge(group_error_acknowledge), .outs(outs),
   .fault_diagnostic_word(fault_diagnostic_word), .machine_state_code(machine_state_code));
